// ---- level_curve.sv ----
// converts between internal channel level and 7-bit controller value
// assumes 10-bit levels; curve select is stable while in use
`timescale 1ns/100ps
module level_curve
(
  // curve select
  input  wire logic       audio_taper_in,
  // level to controller
  input  wire logic [9:0] level_in,
  output logic      [6:0] cc_out,
  // controller to level
  input  wire logic [6:0] cc_in,
  output logic      [9:0] level_out
);

  // square-law taper: cheap, monotonic, close enough to a console fader
  wire [19:0] lvl_sq   = level_in * level_in;
  wire [13:0] cc_sq    = cc_in * cc_in;
  wire [6:0]  lin_cc   = level_in[9:3];
  wire [6:0]  aud_cc   = lvl_sq[19:13];
  wire [9:0]  lin_lvl  = {cc_in, cc_in[6:4]};
  wire [9:0]  aud_lvl  = cc_sq[13:4];

  assign cc_out    = audio_taper_in ? aud_cc : lin_cc;
  assign level_out = audio_taper_in ? aud_lvl : lin_lvl;

endmodule : level_curve

// ---- midi_fader_strip_codec.sv ----
// fader strip message codec: encodes strip, transport and soft events,
// decodes incoming strip messages, holds channel and curve settings.
// assumes one 50 MHz clock, events from same-clock logic, byte links.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module midi_fader_strip_codec
(
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  // register port
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [15:0] RDATA_OUT,
  // strip events from the surface
  input  wire logic        STRIP_EV_VALID_IN,
  input  wire strip_codec_pkg::strip_ev_s STRIP_EV_IN,
  input  wire logic [9:0]  FADER_LEVEL_IN,
  output logic             STRIP_EV_READY_OUT,
  // strip actions from incoming messages
  output logic             KEY_HIT_OUT,
  output logic [1:0]       KEY_KIND_OUT,
  output logic [4:0]       KEY_STRIP_OUT,
  output logic             FADER_SET_OUT,
  output logic [4:0]       FADER_STRIP_OUT,
  output logic [9:0]       FADER_LEVEL_OUT,
  // incoming message bytes, same clock
  input  wire logic        RX_VALID_IN,
  input  wire logic [7:0]  RX_DATA_IN,
  // usb and network byte links
  input  wire logic        USB_READY_IN,
  output strip_codec_pkg::link_byte_s USB_TX_OUT,
  input  wire logic        NET_READY_IN,
  output strip_codec_pkg::link_byte_s NET_TX_OUT
);

  typedef enum {ST_IDLE, ST_SEND, ST_OFF} tx_state_e;
  typedef enum {RX_STATUS, RX_D1, RX_D2} rx_state_e;

  tx_state_e   state_ff;
  rx_state_e   rx_ff;
  logic [3:0]  main_chan_ff;
  logic        curve_ff;
  logic [3:0]  pend_chan_ff;
  logic        pend_curve_ff;
  logic [47:0] msg_ff;
  logic [3:0]  len_ff;
  logic        send_ff;
  logic [6:0]  off_note_ff;
  logic [15:0] soft_ff;
  logic        soft_pend_ff;
  logic [7:0]  mmc_ff;
  logic        mmc_pend_ff;
  logic [15:0] rdata_ff;
  logic [3:0]  rx_stat_ff;
  logic [6:0]  rx_d1_ff;
  logic        key_hit_ff;
  logic [1:0]  key_kind_ff;
  logic [4:0]  key_strip_ff;
  logic        fad_set_ff;
  logic [4:0]  fad_strip_ff;
  logic [9:0]  fad_lvl_ff;
  logic        ev_ready_ff;

  logic        usb_busy;
  logic        net_busy;
  logic [6:0]  fader_cc;
  logic [9:0]  rx_level;

  // strip channel nibble: main setting 1..16 is stored 0..15; +1 wraps
  wire [3:0]   strip_chan   = main_chan_ff + 4'h1;
  wire         links_free   = !usb_busy && !net_busy && !send_ff;
  wire [6:0]   strip_num    = {2'b00, STRIP_EV_IN.strip};
  wire [6:0]   note_base    = (STRIP_EV_IN.kind == strip_codec_pkg::EV_MUTE)
                              ? strip_codec_pkg::MUTE_NOTE_BASE
                              : (STRIP_EV_IN.kind == strip_codec_pkg::EV_SEL)
                              ? strip_codec_pkg::SEL_NOTE_BASE
                              : strip_codec_pkg::LISTEN_NOTE_BASE;
  wire [6:0]   ev_note      = note_base + strip_num;
  wire         is_fader     = STRIP_EV_IN.kind == strip_codec_pkg::EV_FADER;
  wire [47:0]  note_on_msg  = {strip_codec_pkg::ST_NOTE_ON, strip_chan,
                               1'b0, ev_note, 1'b0, strip_codec_pkg::NOTE_VELOCITY,
                               24'h0};
  wire [47:0]  note_off_msg = {strip_codec_pkg::ST_NOTE_OFF, strip_chan,
                               1'b0, off_note_ff, 8'h00, 24'h0};
  wire [47:0]  fader_msg    = {strip_codec_pkg::ST_CTRL, strip_chan, 1'b0,
                               strip_codec_pkg::FADER_CC_BASE + strip_num,
                               1'b0, fader_cc, 24'h0};
  wire [47:0]  mmc_msg      = {strip_codec_pkg::SYSEX_START,
                               strip_codec_pkg::MMC_UNIVERSAL,
                               strip_codec_pkg::MMC_ALL_DEV,
                               strip_codec_pkg::MMC_CMD_SUB,
                               1'b0, mmc_ff[6:0], strip_codec_pkg::SYSEX_END};

  // soft control word: [15:13] kind, [12:7] number, [6:0] value
  wire [2:0]   soft_kind    = soft_ff[15:13];
  wire [6:0]   soft_num     = {1'b0, soft_ff[12:7]};
  wire [6:0]   soft_val     = soft_ff[6:0];
  wire [6:0]   rel_val      = soft_val[6] ? (7'h40 - {1'b0, soft_val[5:0]})
                                          : soft_val;
  wire [47:0]  soft_msg     =
    (soft_kind == 3'(strip_codec_pkg::SOFT_NOTE))
      ? {strip_codec_pkg::ST_NOTE_ON, main_chan_ff, 1'b0, soft_num,
         1'b0, (soft_val == 7'h00) ? strip_codec_pkg::NOTE_VELOCITY : soft_val, 24'h0}
    : (soft_kind == 3'(strip_codec_pkg::SOFT_PROG))
      ? {strip_codec_pkg::ST_PROG, main_chan_ff, 1'b0, soft_val, 32'h0}
    : (soft_kind == 3'(strip_codec_pkg::SOFT_MMC))
      ? {mmc_msg[47:16], 1'b0, soft_val, strip_codec_pkg::SYSEX_END}
    : {strip_codec_pkg::ST_CTRL, main_chan_ff, 1'b0, soft_num, 1'b0,
       (soft_kind == 3'(strip_codec_pkg::SOFT_CC_REL)) ? rel_val : soft_val,
       24'h0};
  wire [3:0]   soft_len     = (soft_kind == 3'(strip_codec_pkg::SOFT_MMC))
                              ? strip_codec_pkg::MAX_MSG_BYTES
                              : (soft_kind == 3'(strip_codec_pkg::SOFT_PROG)) ? 4'h2 : 4'h3;

  // register decode
  wire         wr_setting   = WR_IN && ADDR_IN == strip_codec_pkg::REG_SETTING;
  wire         wr_apply     = WR_IN && ADDR_IN == strip_codec_pkg::REG_APPLY;
  wire         wr_soft      = WR_IN && ADDR_IN == strip_codec_pkg::REG_SOFT;
  wire         wr_mmc       = WR_IN && ADDR_IN == strip_codec_pkg::REG_MMC;
  wire         do_apply     = wr_apply && WDATA_IN[strip_codec_pkg::APPLY_BIT];
  wire         do_cancel    = wr_apply && WDATA_IN[strip_codec_pkg::CANCEL_BIT]
                              && !do_apply;
  wire [15:0]  status_word  = {12'h0, soft_pend_ff, mmc_pend_ff,
                               state_ff != ST_IDLE, usb_busy || net_busy};
  wire [15:0]  rd_word;
  assign rd_word =
    (ADDR_IN == strip_codec_pkg::REG_SETTING) ? {11'h0, pend_curve_ff, pend_chan_ff}
    : (ADDR_IN == strip_codec_pkg::REG_ACTIVE) ? {11'h0, curve_ff, main_chan_ff}
    : (ADDR_IN == strip_codec_pkg::REG_SOFT) ? soft_ff
    : (ADDR_IN == strip_codec_pkg::REG_MMC) ? {8'h0, mmc_ff}
    : (ADDR_IN == strip_codec_pkg::REG_STATUS) ? status_word
    : 16'h0;

  // incoming decode
  wire         rx_is_status = RX_VALID_IN && RX_DATA_IN[7];
  wire         rx_chan_ok   = RX_DATA_IN[3:0] == strip_chan;
  wire         rx_done      = RX_VALID_IN && !RX_DATA_IN[7] && rx_ff == RX_D2;
  wire         rx_note_on   = rx_stat_ff == strip_codec_pkg::ST_NOTE_ON;
  wire         rx_ctrl      = rx_stat_ff == strip_codec_pkg::ST_CTRL;
  wire         rx_key_ok    = rx_done && rx_note_on && RX_DATA_IN[6:0] != 7'h00
                              && rx_d1_ff < 7'h60;
  wire         rx_fad_ok    = rx_done && rx_ctrl && rx_d1_ff < 7'h20;

  // fader events leave as one message; key events as two
  wire         take_strip   = state_ff == ST_IDLE && links_free && STRIP_EV_VALID_IN;
  wire         take_mmc     = state_ff == ST_IDLE && links_free && !STRIP_EV_VALID_IN
                              && mmc_pend_ff;
  wire         take_soft    = state_ff == ST_IDLE && links_free && !STRIP_EV_VALID_IN
                              && !mmc_pend_ff && soft_pend_ff;

  level_curve u_curve
  (
    .audio_taper_in (curve_ff),
    .level_in       (FADER_LEVEL_IN),
    .cc_out         (fader_cc),
    .cc_in          (RX_DATA_IN[6:0]),
    .level_out      (rx_level)
  );

  // same message to both links so they never diverge
  msg_link_tx u_usb
  (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .msg_valid_in  (send_ff),
    .msg_in        (msg_ff),
    .msg_len_in    (len_ff),
    .busy_out      (usb_busy),
    .link_ready_in (USB_READY_IN),
    .link_out      (USB_TX_OUT)
  );

  msg_link_tx u_net
  (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .msg_valid_in  (send_ff),
    .msg_in        (msg_ff),
    .msg_len_in    (len_ff),
    .busy_out      (net_busy),
    .link_ready_in (NET_READY_IN),
    .link_out      (NET_TX_OUT)
  );

  // settings, pending words
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      main_chan_ff  <= strip_codec_pkg::MAIN_CHAN_RESET;
      curve_ff      <= 1'b0;
      pend_chan_ff  <= strip_codec_pkg::MAIN_CHAN_RESET;
      pend_curve_ff <= 1'b0;
      soft_ff       <= 16'h0;
      soft_pend_ff  <= 1'b0;
      mmc_ff        <= 8'h0;
      mmc_pend_ff   <= 1'b0;
      rdata_ff      <= 16'h0;
    end
    else
    begin
      rdata_ff <= RD_IN ? rd_word : 16'h0;
      if (wr_setting)
      begin
        pend_chan_ff  <= WDATA_IN[3:0];
        pend_curve_ff <= WDATA_IN[strip_codec_pkg::CURVE_BIT];
      end
      if (do_apply)
      begin
        main_chan_ff <= pend_chan_ff;
        curve_ff     <= pend_curve_ff;
      end
      else if (do_cancel)
      begin
        pend_chan_ff  <= main_chan_ff;
        pend_curve_ff <= curve_ff;
      end
      if (wr_soft)
        soft_ff <= WDATA_IN;
      // a new request in the take cycle wins over the clear
      soft_pend_ff <= wr_soft || (soft_pend_ff && !take_soft);
      if (wr_mmc)
        mmc_ff <= WDATA_IN[7:0];
      mmc_pend_ff <= wr_mmc || (mmc_pend_ff && !take_mmc);
    end
  end

  // transmit sequencer
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_ff    <= ST_IDLE;
      msg_ff      <= 48'h0;
      len_ff      <= 4'h0;
      send_ff     <= 1'b0;
      off_note_ff <= 7'h00;
      ev_ready_ff <= 1'b0;
    end
    else
    begin
      send_ff     <= 1'b0;
      ev_ready_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
          if (take_strip)
          begin
            ev_ready_ff <= 1'b1;
            send_ff     <= 1'b1;
            len_ff      <= is_fader ? 4'h3 : 4'h3;
            msg_ff      <= is_fader ? fader_msg : note_on_msg;
            off_note_ff <= ev_note;
            state_ff    <= is_fader ? ST_IDLE : ST_OFF;
          end
          else if (take_mmc)
          begin
            send_ff <= 1'b1;
            len_ff  <= strip_codec_pkg::MAX_MSG_BYTES;
            msg_ff  <= mmc_msg;
          end
          else if (take_soft)
          begin
            send_ff <= 1'b1;
            len_ff  <= soft_len;
            msg_ff  <= soft_msg;
          end
        ST_OFF:
          if (links_free)
          begin
            send_ff  <= 1'b1;
            len_ff   <= 4'h3;
            msg_ff   <= note_off_msg;
            state_ff <= ST_IDLE;
          end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // receive parser, running status not supported
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rx_ff        <= RX_STATUS;
      rx_stat_ff   <= 4'h0;
      rx_d1_ff     <= 7'h00;
      key_hit_ff   <= 1'b0;
      key_kind_ff  <= 2'b00;
      key_strip_ff <= 5'h00;
      fad_set_ff   <= 1'b0;
      fad_strip_ff <= 5'h00;
      fad_lvl_ff   <= 10'h000;
    end
    else
    begin
      key_hit_ff <= rx_key_ok;
      fad_set_ff <= rx_fad_ok;
      if (rx_key_ok)
      begin
        key_kind_ff  <= rx_d1_ff[6:5];
        key_strip_ff <= rx_d1_ff[4:0];
      end
      if (rx_fad_ok)
      begin
        fad_strip_ff <= rx_d1_ff[4:0];
        fad_lvl_ff   <= rx_level;
      end
      if (rx_is_status)
      begin
        rx_stat_ff <= RX_DATA_IN[7:4];
        rx_ff      <= rx_chan_ok ? RX_D1 : RX_STATUS;
      end
      else if (RX_VALID_IN)
      begin
        case (rx_ff)
          RX_D1:
          begin
            rx_d1_ff <= RX_DATA_IN[6:0];
            rx_ff    <= RX_D2;
          end
          RX_D2:
            rx_ff <= RX_STATUS;
          default:
            rx_ff <= RX_STATUS;
        endcase
      end
    end
  end

  assign RDATA_OUT          = rdata_ff;
  assign STRIP_EV_READY_OUT = ev_ready_ff;
  assign KEY_HIT_OUT        = key_hit_ff;
  assign KEY_KIND_OUT       = key_kind_ff;
  assign KEY_STRIP_OUT      = key_strip_ff;
  assign FADER_SET_OUT      = fad_set_ff;
  assign FADER_STRIP_OUT    = fad_strip_ff;
  assign FADER_LEVEL_OUT    = fad_lvl_ff;

endmodule : midi_fader_strip_codec

// ---- midi_fader_strip_codec_monitor.sv ----
// assertion monitor for the fader strip codec top ports
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/100ps
module midi_fader_strip_codec_monitor
(
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  // register port
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic        RD_IN,
  input  wire logic [15:0] RDATA_OUT,
  // strip events and incoming bytes
  input  wire logic        STRIP_EV_VALID_IN,
  input  wire logic        STRIP_EV_READY_OUT,
  input  wire logic        RX_VALID_IN,
  input  wire logic        KEY_HIT_OUT,
  input  wire logic [1:0]  KEY_KIND_OUT,
  input  wire logic        FADER_SET_OUT
);
  default clocking mon_cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  rdata_idle_a : assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
    else $error("read data outside read answer");
  rdata_unmap_a : assert property (RD_IN && ADDR_IN > 4'h5 |=> RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  ready_cause_a : assert property (STRIP_EV_READY_OUT |-> $past(STRIP_EV_VALID_IN))
    else $error("event accepted without request");
  ready_gap_a : assert property (STRIP_EV_READY_OUT |=> !STRIP_EV_READY_OUT [*3])
    else $error("event accepted mid message");
  hit_cause_a : assert property (KEY_HIT_OUT |-> $past(RX_VALID_IN))
    else $error("key hit without incoming byte");
  hit_pulse_a : assert property (KEY_HIT_OUT |=> !KEY_HIT_OUT [*2])
    else $error("key hit too close");
  fader_cause_a : assert property (FADER_SET_OUT |-> $past(RX_VALID_IN) && !KEY_HIT_OUT)
    else $error("fader set without controller message");
  key_kind_a : assert property (KEY_HIT_OUT |-> KEY_KIND_OUT != 2'h3)
    else $error("key hit with fader kind");

  cover property (KEY_HIT_OUT);
  cover property (FADER_SET_OUT);
  cover property (STRIP_EV_READY_OUT);
  cover property (RD_IN && ADDR_IN > 4'h5);
endmodule : midi_fader_strip_codec_monitor

bind midi_fader_strip_codec midi_fader_strip_codec_monitor u_midi_fader_strip_codec_monitor
(
  .REF_CLK_IN         (REF_CLK_IN),
  .RST_N_IN           (RST_N_IN),
  .ADDR_IN            (ADDR_IN),
  .RD_IN              (RD_IN),
  .RDATA_OUT          (RDATA_OUT),
  .STRIP_EV_VALID_IN  (STRIP_EV_VALID_IN),
  .STRIP_EV_READY_OUT (STRIP_EV_READY_OUT),
  .RX_VALID_IN        (RX_VALID_IN),
  .KEY_HIT_OUT        (KEY_HIT_OUT),
  .KEY_KIND_OUT       (KEY_KIND_OUT),
  .FADER_SET_OUT      (FADER_SET_OUT)
);

// ---- midi_fader_strip_codec_tb_top.sv ----
// testbench: strips, settings, incoming messages, transport, soft sends
// assumes the link sink model and bound monitor are compiled before it
`timescale 1ns/100ps
module midi_fader_strip_codec_tb_top;
  logic                        clk;
  logic                        rst_n;
  logic [3:0]                  addr;
  logic [15:0]                 wdata;
  logic                        wr;
  logic                        rd;
  logic [15:0]                 rdata;
  logic                        ev_valid;
  strip_codec_pkg::strip_ev_s  ev;
  logic [9:0]                  lvl;
  logic                        ev_ready;
  logic                        hit;
  logic [1:0]                  hit_kind;
  logic [4:0]                  hit_strip;
  logic                        fset;
  logic [4:0]                  fstrip;
  logic [9:0]                  flvl;
  logic                        rx_valid;
  logic [7:0]                  rx_data;
  logic                        usb_rdy;
  logic                        net_rdy;
  logic                        usb_slow;
  strip_codec_pkg::link_byte_s usb_tx;
  strip_codec_pkg::link_byte_s net_tx;
  int                          fail_count;
  int                          checks_done;
  logic [7:0]                  exp_q [$];

  midi_fader_strip_codec u_midi_fader_strip_codec
  (
    .REF_CLK_IN         (clk),
    .RST_N_IN           (rst_n),
    .ADDR_IN            (addr),
    .WDATA_IN           (wdata),
    .WR_IN              (wr),
    .RD_IN              (rd),
    .RDATA_OUT          (rdata),
    .STRIP_EV_VALID_IN  (ev_valid),
    .STRIP_EV_IN        (ev),
    .FADER_LEVEL_IN     (lvl),
    .STRIP_EV_READY_OUT (ev_ready),
    .KEY_HIT_OUT        (hit),
    .KEY_KIND_OUT       (hit_kind),
    .KEY_STRIP_OUT      (hit_strip),
    .FADER_SET_OUT      (fset),
    .FADER_STRIP_OUT    (fstrip),
    .FADER_LEVEL_OUT    (flvl),
    .RX_VALID_IN        (rx_valid),
    .RX_DATA_IN         (rx_data),
    .USB_READY_IN       (usb_rdy),
    .USB_TX_OUT         (usb_tx),
    .NET_READY_IN       (net_rdy),
    .NET_TX_OUT         (net_tx)
  );
  midi_link_sink u_usb_sink (.clk_in(clk), .rst_n_in(rst_n), .slow_in(usb_slow),
                             .link_in(usb_tx), .ready_out(usb_rdy));
  midi_link_sink u_net_sink (.clk_in(clk), .rst_n_in(rst_n), .slow_in(1'b0),
                             .link_in(net_tx), .ready_out(net_rdy));

  always #10 clk = ~clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic give_up;
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    test_done();
  endtask : give_up

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd

  task automatic send_ev(input logic [1:0] k, input logic [4:0] s, input logic [9:0] l);
    @(posedge clk);
    ev_valid <= 1'b1;
    ev       <= strip_codec_pkg::strip_ev_s'({k, s, 7'h00});
    lvl      <= l;
    for (int i = 0; i <= 50; i++)
    begin
      @(negedge clk);
      if (ev_ready === 1'b1)
        break;
      if (i == 50)
        give_up();
    end
    @(posedge clk);
    ev_valid <= 1'b0;
  endtask : send_ev

  // both links must carry the same whole messages, nothing extra
  task automatic expect_bytes;
    for (int i = 0; i <= 400; i++)
    begin
      @(negedge clk);
      if (u_usb_sink.got.size() >= exp_q.size() && u_net_sink.got.size() >= exp_q.size())
        break;
      if (i == 400)
        give_up();
    end
    repeat (4) @(negedge clk);
    check(16'(u_usb_sink.got.size()), 16'(exp_q.size()));
    check(16'(u_net_sink.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
    begin
      check({8'h00, u_usb_sink.got[i]}, {8'h00, exp_q[i]});
      check({8'h00, u_net_sink.got[i]}, {8'h00, exp_q[i]});
    end
    u_usb_sink.got.delete();
    u_net_sink.got.delete();
    exp_q.delete();
  endtask : expect_bytes

  task automatic rx_msg(input logic [23:0] m, output logic h, output logic f);
    h = 1'b0;
    f = 1'b0;
    for (int i = 2; i >= 0; i--)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= m[8*i +: 8];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      h = h | hit;
      f = f | fset;
    end
  endtask : rx_msg

  task automatic test_keys;
    logic [15:0] d;
    reg_rd(strip_codec_pkg::REG_ACTIVE, d);
    check(d, 16'h0000);
    reg_rd(4'hF, d);
    check(d, 16'h0000);
    for (int k = 0; k < 3; k++)
      for (int s = 0; s < 32; s += 31)
      begin
        send_ev(2'(k), 5'(s), 10'h000);
        exp_q = '{8'h91, 8'(32*k+s), 8'h7F, 8'h81, 8'(32*k+s), 8'h00};
        expect_bytes();
      end
    send_ev(2'h3, 5'h1F, 10'h3FF);
    exp_q = '{8'hB1, 8'h1F, 8'h7F};
    expect_bytes();
    $display("test keys done");
  endtask : test_keys

  task automatic test_settings;
    logic [15:0] d;
    reg_wr(strip_codec_pkg::REG_SETTING, 16'h001F);
    reg_rd(strip_codec_pkg::REG_ACTIVE, d);
    check(d, 16'h0000);
    reg_wr(strip_codec_pkg::REG_APPLY, 16'h0002);
    reg_rd(strip_codec_pkg::REG_SETTING, d);
    check(d, 16'h0000);
    send_ev(2'h3, 5'h00, 10'h200);
    exp_q = '{8'hB1, 8'h00, 8'h40};
    expect_bytes();
    reg_wr(strip_codec_pkg::REG_SETTING, 16'h001F);
    reg_wr(strip_codec_pkg::REG_APPLY, 16'h0001);
    reg_rd(strip_codec_pkg::REG_ACTIVE, d);
    check(d, 16'h001F);
    send_ev(2'h3, 5'h00, 10'h200);
    exp_q = '{8'hB0, 8'h00, 8'h20};
    expect_bytes();
    $display("test settings done");
  endtask : test_settings

  task automatic test_rx;
    logic h;
    logic f;
    rx_msg(24'h90457F, h, f);
    check({15'h0000, h}, 16'h0001);
    check({9'h000, hit_kind, hit_strip}, {9'h000, 2'h2, 5'h05});
    rx_msg(24'h91057F, h, f);
    check({15'h0000, h}, 16'h0000);
    rx_msg(24'hB01E40, h, f);
    check({14'h0000, h, f}, 16'h0001);
    check({11'h000, fstrip}, 16'h001E);
    // audio taper is active here: controller 40h squared lands on level 100h
    check({6'h00, flvl}, 16'h0100);
    $display("test rx done");
  endtask : test_rx

  task automatic test_sends;
    logic [15:0] d;
    usb_slow = 1'b1;
    reg_wr(strip_codec_pkg::REG_MMC, 16'h0002);
    send_ev(2'h0, 5'h02, 10'h000);
    exp_q = '{8'hF0, 8'h7F, 8'h7F, 8'h06, 8'h02, 8'hF7,
              8'h90, 8'h02, 8'h7F, 8'h80, 8'h02, 8'h00};
    expect_bytes();
    // kind 2 carries a negative step so the sign path is exercised
    for (int k = 0; k < 5; k++)
    begin
      reg_wr(strip_codec_pkg::REG_SOFT, {3'(k), 6'h01, (k == 2) ? 7'h45 : 7'h05});
      case (k)
        0: exp_q = '{8'h9F, 8'h01, 8'h05};
        1: exp_q = '{8'hBF, 8'h01, 8'h05};
        2: exp_q = '{8'hBF, 8'h01, 8'h3B};
        3: exp_q = '{8'hF0, 8'h7F, 8'h7F, 8'h06, 8'h05, 8'hF7};
        default: exp_q = '{8'hCF, 8'h05};
      endcase
      expect_bytes();
      reg_rd(strip_codec_pkg::REG_STATUS, d);
      check(d, 16'h0000);
    end
    $display("test sends done");
  endtask : test_sends

  initial
  begin
    clk      = 1'b0;
    rst_n    = 1'b0;
    addr     = 4'h0;
    wdata    = 16'h0000;
    wr       = 1'b0;
    rd       = 1'b0;
    ev_valid = 1'b0;
    ev       = '0;
    lvl      = 10'h000;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    usb_slow = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    test_keys();
    test_settings();
    test_rx();
    test_sends();
    test_done();
  end
endmodule : midi_fader_strip_codec_tb_top

// ---- midi_link_sink.sv ----
// byte link sink standing in for the host side of one link
// assumes link bytes are registered one-cycle pulses on the codec clock
`timescale 1ns/100ps
module midi_link_sink
(
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // pacing select
  input  wire logic                        slow_in,
  // byte link
  input  wire strip_codec_pkg::link_byte_s link_in,
  output logic                             ready_out
);
  logic [7:0] got [$];
  logic       tick_ff;

  // slow mode takes every other cycle, so back-pressure is exercised
  assign ready_out = !slow_in || tick_ff;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tick_ff <= 1'b0;
    else
      tick_ff <= !tick_ff;
  end

  always @(posedge clk_in)
  begin
    if (rst_n_in && link_in.valid)
      got.push_back(link_in.data);
  end
endmodule : midi_link_sink

// ---- msg_link_tx.sv ----
// serialises one whole message at a time onto a byte link
// assumes the link sink takes a byte on any cycle ready is high
`timescale 1ns/100ps
module msg_link_tx
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // message to send
  input  wire logic        msg_valid_in,
  input  wire logic [47:0] msg_in,
  input  wire logic [3:0]  msg_len_in,
  output logic             busy_out,
  // link
  input  wire logic        link_ready_in,
  output strip_codec_pkg::link_byte_s link_out
);

  logic [47:0] shift_ff;
  logic [3:0]  left_ff;
  strip_codec_pkg::link_byte_s byte_ff;

  wire         take = link_ready_in && (left_ff != 4'h0);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shift_ff <= 48'h0;
      left_ff  <= 4'h0;
      byte_ff  <= '0;
    end
    else if (msg_valid_in && left_ff == 4'h0)
    begin
      shift_ff <= msg_in;
      left_ff  <= msg_len_in;
      byte_ff  <= '0;
    end
    else
    begin
      // no byte from another message can slip in until left_ff is empty
      byte_ff.valid <= take;
      byte_ff.data  <= shift_ff[47:40];
      if (take)
      begin
        shift_ff <= {shift_ff[39:0], 8'h00};
        left_ff  <= left_ff - 4'h1;
      end
    end
  end

  assign busy_out = (left_ff != 4'h0) || msg_valid_in;
  assign link_out = byte_ff;

endmodule : msg_link_tx

// ---- strip_codec_pkg.sv ----
// shared constants and carriers for the fader strip message codec
// assumes a single 50 MHz clock domain and byte-wide message links
package strip_codec_pkg;

  localparam int          NUM_STRIPS     = 32;
  localparam logic [6:0]  MUTE_NOTE_BASE = 7'h00;
  localparam logic [6:0]  SEL_NOTE_BASE  = 7'h20;
  localparam logic [6:0]  LISTEN_NOTE_BASE = 7'h40;
  localparam logic [6:0]  FADER_CC_BASE  = 7'h00;
  localparam logic [3:0]  MAIN_CHAN_RESET = 4'h0;   // main channel 1, strips on 2
  localparam logic [3:0]  ST_NOTE_ON     = 4'h9;
  localparam logic [3:0]  ST_NOTE_OFF    = 4'h8;
  localparam logic [3:0]  ST_CTRL        = 4'hB;
  localparam logic [3:0]  ST_PROG        = 4'hC;
  localparam logic [6:0]  NOTE_VELOCITY  = 7'h7F;
  localparam logic [7:0]  SYSEX_START    = 8'hF0;
  localparam logic [7:0]  SYSEX_END      = 8'hF7;
  localparam logic [7:0]  MMC_ALL_DEV    = 8'h7F;
  localparam logic [7:0]  MMC_UNIVERSAL  = 8'h7F;
  localparam logic [7:0]  MMC_CMD_SUB    = 8'h06;
  localparam logic [3:0]  MAX_MSG_BYTES  = 4'h6;

  // software register offsets
  localparam logic [3:0]  REG_SETTING    = 4'h0;
  localparam logic [3:0]  REG_APPLY      = 4'h1;
  localparam logic [3:0]  REG_ACTIVE     = 4'h2;
  localparam logic [3:0]  REG_SOFT       = 4'h3;
  localparam logic [3:0]  REG_MMC        = 4'h4;
  localparam logic [3:0]  REG_STATUS     = 4'h5;
  localparam int          APPLY_BIT      = 0;
  localparam int          CANCEL_BIT     = 1;
  localparam int          CURVE_BIT      = 4;

  typedef enum logic [2:0] {
    SOFT_NOTE, SOFT_CC_ABS, SOFT_CC_REL, SOFT_MMC, SOFT_PROG
  } soft_kind_e;

  typedef enum logic [1:0] {
    EV_MUTE, EV_SEL, EV_LISTEN, EV_FADER
  } strip_ev_e;

  typedef struct packed {
    strip_ev_e  kind;
    logic [4:0] strip;
    logic [6:0] value;
  } strip_ev_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } link_byte_s;

endpackage : strip_codec_pkg
